//--- common/huhp_pkg.sv
/*
 * Shared constants and types of the host-facing HCI serial port.
 * Assumes a 250 MHz core clock feeding the whole port.
 */
package huhp_pkg;

    // Core clock and line rates, in Hz and bits per second
    localparam int unsigned CLK_HZ           = 250_000_000;
    localparam int unsigned BAUD_MIN_BPS     = 9_600;
    localparam int unsigned BAUD_MAX_BPS     = 4_000_000;
    localparam int unsigned BAUD_DEFAULT_BPS = 115_200;

    // Divisor width and derived cycle-per-bit counts
    localparam int          DIV_W            = 16;
    localparam logic [15:0] DIV_MIN          = 16'(CLK_HZ / BAUD_MAX_BPS);
    localparam int unsigned DIV_MAX_CNT      = CLK_HZ / BAUD_MIN_BPS;
    localparam int unsigned DIV_DEFAULT_CNT  =
        (CLK_HZ + BAUD_DEFAULT_BPS / 2) / BAUD_DEFAULT_BPS;

    // Buffer sizes and flow-control margin, in bytes
    localparam int          FIFO_BYTES       = 1040;
    localparam int          RTS_MARGIN       = 4;

    // In-band control characters
    localparam logic [7:0]  CH_XON           = 8'h11;
    localparam logic [7:0]  CH_XOFF          = 8'h13;
    localparam logic [7:0]  SLIP_END         = 8'hc0;
    localparam logic [7:0]  SLIP_ESC         = 8'hdb;
    localparam logic [7:0]  SLIP_ESC_END     = 8'hdc;
    localparam logic [7:0]  SLIP_ESC_ESC     = 8'hdd;

    // Host transport framing
    typedef enum logic [1:0] {
        HUHP_H4     = 2'b00,
        HUHP_H4_EXT = 2'b01,
        HUHP_H5     = 2'b10
    } huhp_mode_t;

    // Character engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } huhp_bit_st_t;

    // Received byte with frame delimiter mark
    typedef struct packed {
        logic       delim;
        logic [7:0] data;
    } huhp_rx_t;

    // Static port configuration
    typedef struct packed {
        huhp_mode_t mode;
        logic       sw_flow;
        logic       slip;
    } huhp_cfg_t;

endpackage : huhp_pkg

//--- design/huhp_uart.sv
/*
 * Byte FIFO and the host-facing serial port with flow control,
 * rate detection, SLIP byte stuffing and line wake detection.
 * Assumes the serial pins are asynchronous; the configuration,
 * stream and sleep inputs come from logic on ref_clk_in.
 */
`timescale 1ns/1ps

module huhp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int LW    = $clog2(DEPTH + 1)
) (
    input  wire logic          ref_clk_in,    // Core clock
    input  wire logic          resetn_in,     // Async reset, active low
    input  wire logic          wr_valid_in,   // Write offered
    input  wire logic [W-1:0]  wr_data_in,    // Write word
    output logic               wr_ready_out,  // Room for a word
    output logic               rd_valid_out,  // Word available
    output logic [W-1:0]       rd_data_out,   // Head word
    input  wire logic          rd_ready_in,   // Head word taken
    output logic [LW-1:0]      level_out      // Words held
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic          push;
    logic          pop;
    logic [LW-1:0] level_d;

    // Handshakes on both sides
    assign push = wr_valid_in && wr_ready_out;
    assign pop  = rd_valid_out && rd_ready_in;
    assign rd_data_out = mem_q[rd_ptr_q];
    assign level_d = level_out + LW'(push) - LW'(pop);

    // Storage
    always_ff @(posedge ref_clk_in)
    begin
        if (push)
            mem_q[wr_ptr_q] <= wr_data_in;
    end

    // Pointers, level and registered flags
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr_q     <= '0;
            rd_ptr_q     <= '0;
            level_out    <= '0;
            wr_ready_out <= 1'b1;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0
                                                          : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0
                                                          : rd_ptr_q + 1'b1;
            level_out    <= level_d;
            wr_ready_out <= (level_d != LW'(DEPTH));
            rd_valid_out <= (level_d != '0);
        end
    end
endmodule : huhp_fifo

// Behaviour
// - Four-wire link: receive in, transmit out, request out, clear in.
// - Rate divisor accepted only between 9600 bps and 4.0 Mbps.
// - Rate detection measures a start pulse and reports the divisor.
// - A rate-change command reloads the divisor during operation.
// - Separate receive and transmit FIFOs of 1040 bytes each.
// - Both FIFOs reached as streams by the on-chip bus engines.
// - Out of reset the line runs at 115.2 kbaud.
// - Carries standard four-wire, vendor four-wire and three-wire framing.
// - Three-wire framing ignores the clear input for starting characters; clear changes still raise a wake request.
// - XOFF received pauses sending; XON resumes it.
// - SLIP delimiter and escape bytes are stuffed and removed in logic.
// - While asleep, receive or clear activity raises a wake request.
// - Divisor is set by a downloaded value or by rate detection.
// - The default divisor rounds to nearest so its rate error stays within two percent.
// - Start bit begins within 1.5 bit periods of clear going low.
// - Request goes high within half a bit after stop midpoint.
module huhp_uart
    import huhp_pkg::*;
#(
    parameter int DEPTH       = FIFO_BYTES,
    parameter int DIV_MAX     = DIV_MAX_CNT,
    parameter int DIV_DEFAULT = DIV_DEFAULT_CNT,
    parameter int MARGIN      = RTS_MARGIN
) (
    input  wire logic             ref_clk_in,            // Core clock
    input  wire logic             resetn_in,             // Async reset
    input  wire logic             serial_rx_in,          // Line from host
    input  wire logic             clear_to_send_n_in,    // Host may take
    output logic                  serial_tx_out,         // Line to host
    output logic                  request_to_send_n_out, // We may take
    input  wire huhp_pkg::huhp_cfg_t cfg_in,             // Framing setup
    input  wire logic [15:0]      baud_div_in,           // Cycles per bit
    input  wire logic             baud_load_in,          // Load divisor
    input  wire logic             autobaud_arm_in,       // Start detection
    output logic [15:0]           autobaud_div_out,      // Detected divisor
    output logic                  autobaud_done_out,     // Detection pulse
    input  wire logic             sleep_in,              // Chip asleep
    output logic                  wake_out,              // Wake request
    input  wire logic [7:0]       tx_data_in,            // Byte to send
    input  wire logic             tx_valid_in,           // Byte offered
    output logic                  tx_ready_out,          // Transmit room
    output huhp_pkg::huhp_rx_t    rx_data_out,           // Received byte
    output logic                  rx_valid_out,          // Byte ready
    input  wire logic             rx_ready_in            // Byte taken
);
    import huhp_pkg::*;
    localparam int LW = $clog2(DEPTH + 1);

    logic         rx_s1_q, rx_s2_q, rx_s3_q;
    logic         cts_s1_q, cts_s2_q, cts_s3_q;
    logic         rx_fall;
    logic [15:0]  div_q;
    logic         div_ok;
    logic         cfg_seen_q;
    huhp_bit_st_t rx_st_q, tx_st_q;
    logic [15:0]  rx_cnt_q, tx_cnt_q;
    logic [2:0]   rx_bit_q, tx_bit_q;
    logic [7:0]   rx_sh_q, tx_sh_q;
    logic         rx_got_q;
    logic         xoff_q, esc_q;
    logic         push;
    huhp_rx_t     push_d;
    logic         rxf_ready, rxf_valid;
    huhp_rx_t     rxf_data;
    logic [LW-1:0] rx_level;
    logic         rx_pop;
    logic         txf_valid;
    logic [7:0]   txf_data;
    logic         tx_take;
    logic         cts_ok;
    logic         pend_q;
    logic [7:0]   pend_byte_q;
    logic         abd_arm_q, abd_meas_q;
    logic [15:0]  abd_cnt_q;

    // Two-stage synchronisers plus an edge stage
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            {rx_s3_q, rx_s2_q, rx_s1_q}    <= 3'h7;
            {cts_s3_q, cts_s2_q, cts_s1_q} <= 3'h7;
        end
        else
        begin
            {rx_s3_q, rx_s2_q, rx_s1_q}    <= {rx_s2_q, rx_s1_q,
                                               serial_rx_in};
            {cts_s3_q, cts_s2_q, cts_s1_q} <= {cts_s2_q, cts_s1_q,
                                               clear_to_send_n_in};
        end
    end
    assign rx_fall = rx_s3_q && !rx_s2_q;
    assign div_ok  = (baud_div_in >= DIV_MIN) &&
                     (baud_div_in <= 16'(DIV_MAX));

    // Divisor: default, host reload, or detected value
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            div_q      <= 16'(DIV_DEFAULT);
            cfg_seen_q <= 1'b0;
        end
        else if (baud_load_in && div_ok)
        begin
            div_q      <= baud_div_in;
            cfg_seen_q <= 1'b1;
        end
        else if (autobaud_done_out)
        begin
            div_q      <= autobaud_div_out;
            cfg_seen_q <= 1'b1;
        end
    end

    // Rate detection: width of the first low pulse after arming
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            abd_arm_q         <= 1'b0;
            abd_meas_q        <= 1'b0;
            abd_cnt_q         <= '0;
            autobaud_div_out  <= 16'(DIV_DEFAULT);
            autobaud_done_out <= 1'b0;
        end
        else
        begin
            autobaud_done_out <= 1'b0;
            if (autobaud_arm_in)
                abd_arm_q <= 1'b1;
            else if (abd_arm_q && rx_fall)
            begin
                abd_arm_q  <= 1'b0;
                abd_meas_q <= 1'b1;
                abd_cnt_q  <= 16'h0001;
            end
            else if (abd_meas_q)
            begin
                if (rx_s2_q)
                begin
                    abd_meas_q        <= 1'b0;
                    autobaud_done_out <= 1'b1;
                    autobaud_div_out  <= (abd_cnt_q < DIV_MIN) ? DIV_MIN
                                                               : abd_cnt_q;
                end
                else if (abd_cnt_q < 16'(DIV_MAX))
                    abd_cnt_q <= abd_cnt_q + 16'h0001;
            end
        end
    end

    // Receiver: samples each bit at its midpoint
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_st_q  <= ST_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q  <= '0;
            rx_got_q <= 1'b0;
        end
        else
        begin
            rx_got_q <= 1'b0;
            if (rx_cnt_q != '0)
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            unique case (rx_st_q)
                ST_IDLE:
                    if (rx_fall && !abd_arm_q && !abd_meas_q)
                    begin
                        rx_st_q  <= ST_START;
                        rx_cnt_q <= div_q >> 1;
                    end
                ST_START:
                    if (rx_cnt_q == '0)
                    begin
                        rx_st_q  <= rx_s2_q ? ST_IDLE : ST_DATA;
                        rx_cnt_q <= div_q - 16'h0001;
                        rx_bit_q <= '0;
                    end
                ST_DATA:
                    if (rx_cnt_q == '0)
                    begin
                        rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        rx_cnt_q <= div_q - 16'h0001;
                        if (rx_bit_q == 3'h7)
                            rx_st_q <= ST_STOP;
                    end
                ST_STOP:
                    if (rx_cnt_q == '0)
                    begin
                        rx_st_q  <= ST_IDLE;
                        rx_got_q <= rx_s2_q;   // Bad stop drops the byte
                    end
            endcase
        end
    end

    // Received byte filter: flow characters and SLIP removal
    always_comb
    begin
        push   = 1'b0;
        push_d = '{delim: 1'b0, data: rx_sh_q};
        if (rx_got_q)
        begin
            if (cfg_in.sw_flow && (rx_sh_q == CH_XON ||
                                   rx_sh_q == CH_XOFF))
                push = 1'b0;
            else if (cfg_in.slip && esc_q)
            begin
                push = 1'b1;
                if (rx_sh_q == SLIP_ESC_END)
                    push_d.data = SLIP_END;
                else if (rx_sh_q == SLIP_ESC_ESC)
                    push_d.data = SLIP_ESC;
            end
            else if (cfg_in.slip && rx_sh_q == SLIP_ESC)
                push = 1'b0;
            else
            begin
                push         = 1'b1;
                push_d.delim = cfg_in.slip && (rx_sh_q == SLIP_END);
            end
        end
    end

    // Pause state and SLIP escape tracking
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            xoff_q <= 1'b0;
            esc_q  <= 1'b0;
        end
        else if (rx_got_q)
        begin
            if (cfg_in.sw_flow && rx_sh_q == CH_XOFF)
                xoff_q <= 1'b1;
            else if (cfg_in.sw_flow && rx_sh_q == CH_XON)
                xoff_q <= 1'b0;
            else
                esc_q <= cfg_in.slip && !esc_q && (rx_sh_q == SLIP_ESC);
        end
    end

    // Receive FIFO toward the bus side
    huhp_fifo #(.W($bits(huhp_rx_t)), .DEPTH(DEPTH)) u_rx_fifo (
        .ref_clk_in   (ref_clk_in),
        .resetn_in    (resetn_in),
        .wr_valid_in  (push),
        .wr_data_in   (push_d),
        .wr_ready_out (rxf_ready),
        .rd_valid_out (rxf_valid),
        .rd_data_out  (rxf_data),
        .rd_ready_in  (rx_pop),
        .level_out    (rx_level)
    );

    // Output stage so the read port comes from flops
    assign rx_pop = rxf_valid && (!rx_valid_out || rx_ready_in);
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_valid_out <= 1'b0;
            rx_data_out  <= '0;
        end
        else if (rx_pop)
        begin
            rx_valid_out <= 1'b1;
            rx_data_out  <= rxf_data;
        end
        else if (rx_ready_in)
            rx_valid_out <= 1'b0;
    end

    // Request line follows free space in the receive FIFO
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            request_to_send_n_out <= 1'b1;
        else
            request_to_send_n_out <=
                (int'(rx_level) >= DEPTH - MARGIN);
    end

    // Transmit FIFO from the bus side
    huhp_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
        .ref_clk_in   (ref_clk_in),
        .resetn_in    (resetn_in),
        .wr_valid_in  (tx_valid_in),
        .wr_data_in   (tx_data_in),
        .wr_ready_out (tx_ready_out),
        .rd_valid_out (txf_valid),
        .rd_data_out  (txf_data),
        .rd_ready_in  (tx_take),
        .level_out    ()
    );

    // Start gate: clear line, or none in three-wire mode
    assign cts_ok  = (cfg_in.mode == HUHP_H5) || !cts_s2_q;
    assign tx_take = (tx_st_q == ST_IDLE) && !pend_q && txf_valid &&
                     cts_ok && !xoff_q;

    // Transmitter with SLIP stuffing
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tx_st_q       <= ST_IDLE;
            tx_cnt_q      <= '0;
            tx_bit_q      <= '0;
            tx_sh_q       <= '0;
            serial_tx_out <= 1'b1;
            pend_q        <= 1'b0;
            pend_byte_q   <= '0;
        end
        else
        begin
            if (tx_cnt_q != '0)
                tx_cnt_q <= tx_cnt_q - 16'h0001;
            unique case (tx_st_q)
                ST_IDLE:
                    if ((pend_q && cts_ok && !xoff_q) || tx_take)
                    begin
                        tx_st_q       <= ST_START;
                        serial_tx_out <= 1'b0;
                        tx_cnt_q      <= div_q - 16'h0001;
                        tx_sh_q       <= pend_q ? pend_byte_q : txf_data;
                        pend_q        <= 1'b0;
                        if (tx_take && cfg_in.slip &&
                            (txf_data == SLIP_END || txf_data == SLIP_ESC))
                        begin
                            tx_sh_q     <= SLIP_ESC;
                            pend_q      <= 1'b1;
                            pend_byte_q <= (txf_data == SLIP_END)
                                           ? SLIP_ESC_END : SLIP_ESC_ESC;
                        end
                    end
                ST_START:
                    if (tx_cnt_q == '0)
                    begin
                        tx_st_q       <= ST_DATA;
                        serial_tx_out <= tx_sh_q[0];
                        tx_sh_q       <= tx_sh_q >> 1;
                        tx_bit_q      <= '0;
                        tx_cnt_q      <= div_q - 16'h0001;
                    end
                ST_DATA:
                    if (tx_cnt_q == '0)
                    begin
                        tx_cnt_q <= div_q - 16'h0001;
                        tx_bit_q <= tx_bit_q + 3'h1;
                        tx_sh_q  <= tx_sh_q >> 1;
                        if (tx_bit_q == 3'h7)
                        begin
                            tx_st_q       <= ST_STOP;
                            serial_tx_out <= 1'b1;
                        end
                        else
                            serial_tx_out <= tx_sh_q[0];
                    end
                ST_STOP:
                    if (tx_cnt_q == '0)
                        tx_st_q <= ST_IDLE;
            endcase
        end
    end

    // Wake request on line activity while asleep
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            wake_out <= 1'b0;
        else if (sleep_in && (rx_fall || (cts_s2_q != cts_s3_q)))
            wake_out <= 1'b1;
        else if (!sleep_in)
            wake_out <= 1'b0;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_default_rate: assert property (
        !cfg_seen_q |-> div_q == 16'(DIV_DEFAULT))
        else $error("divisor left default without a load");
    a_div_range: assert property (
        cfg_seen_q |-> div_q >= DIV_MIN && div_q <= 16'(DIV_MAX))
        else $error("divisor outside rate range");
    a_baud_reload: assert property (
        baud_load_in && div_ok |=> div_q == $past(baud_div_in))
        else $error("rate command not applied");
    a_start_on_cts: assert property (
        tx_st_q == ST_IDLE && txf_valid && !pend_q && !xoff_q &&
        !cts_s2_q |=> tx_st_q == ST_START && !serial_tx_out)
        else $error("start bit late after clear");
    a_xoff_hold: assert property (
        xoff_q && tx_st_q == ST_IDLE |=> tx_st_q == ST_IDLE)
        else $error("sent while paused");
    a_cts_hold: assert property (
        cfg_in.mode != HUHP_H5 && cts_s2_q && tx_st_q == ST_IDLE
        |=> tx_st_q == ST_IDLE)
        else $error("sent while clear deasserted");
    a_idle_high: assert property (
        tx_st_q == ST_IDLE || tx_st_q == ST_STOP |-> serial_tx_out)
        else $error("line not high outside character");
    a_rts_full: assert property (
        int'(rx_level) >= DEPTH - MARGIN |=> request_to_send_n_out)
        else $error("request held low near full");
    a_wake_raise: assert property (
        sleep_in && rx_fall |=> wake_out)
        else $error("wake missed on activity");
    a_slip_escape: assert property (
        tx_take && cfg_in.slip && txf_data == SLIP_END
        |=> pend_q && pend_byte_q == SLIP_ESC_END && tx_sh_q == SLIP_ESC)
        else $error("delimiter not escaped");
endmodule : huhp_uart

//--- testbench/huhp_host_model.sv
/* Host side serial model: sends and collects 8N1 characters.
   Assumes the port's transmit line runs at DIV cycles per bit. */
`timescale 1ns/1ps
module huhp_host_model #(
    parameter int DIV = 64
) (
    input  wire logic clk_in,   // Core clock
    input  wire logic line_in,  // Port transmit line
    output logic      line_out  // Port receive line
);
    logic [7:0] got_q[$];
    // Collect characters, sampling each bit at its middle
    initial
    begin
        logic [7:0] b;
        forever
        begin
            @(negedge line_in);
            repeat (DIV / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(posedge clk_in);
                b[i] = line_in;
            end
            repeat (DIV) @(posedge clk_in);
            got_q.push_back(b);
        end
    end
    // Send one character at d cycles per bit; same rate
    task automatic send(input logic [7:0] b, input int d);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            line_out <= f[i];
            repeat (d) @(posedge clk_in);
        end
    endtask : send
    initial line_out = 1'b1; // Idle high
endmodule : huhp_host_model

//--- testbench/tb_top.sv
/* Self-checking bench of the serial port against queue models.
   Assumes a host model on the line and DIV cycles per bit. */
`timescale 1ns/1ps
module tb_top;
    import huhp_pkg::*;
    localparam int DIV = 64;
    logic ref_clk_in = 1'b0, resetn_in = 1'b0, cts_n = 1'b0;
    logic sleep = 1'b0, arm = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic tx_line, rx_line, rts_n, tx_ready, rx_valid, wake, ab_done;
    logic [7:0] tx_data = 8'h00;
    logic [15:0] bdiv = 16'h0000;
    logic bload = 1'b0;
    int ab_pulses = 0;
    logic [15:0] ab_div;
    logic [31:0] seed = 32'h5b; // 91
    huhp_rx_t rx_data;
    huhp_cfg_t cfg = '{HUHP_H4, 1'b0, 1'b0};
    logic [7:0] exp_tx[$], exp_rx[$];
    int bad_count = 0, checks = 0;
    // Clock at 250 MHz
    always #2 ref_clk_in = ~ref_clk_in;
    // Count detection pulses as sampled at each rising edge
    always @(posedge ref_clk_in) ab_pulses += int'(ab_done === 1'b1);
    huhp_host_model #(.DIV(DIV)) host (.clk_in(ref_clk_in),
        .line_in(tx_line), .line_out(rx_line));
    huhp_uart #(.DEPTH(16), .DIV_MAX(80), .DIV_DEFAULT(DIV), .MARGIN(4))
    dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .serial_rx_in(rx_line), .clear_to_send_n_in(cts_n),
        .serial_tx_out(tx_line), .request_to_send_n_out(rts_n),
        .cfg_in(cfg), .baud_div_in(bdiv), .baud_load_in(bload),
        .autobaud_arm_in(arm), .autobaud_div_out(ab_div),
        .autobaud_done_out(ab_done), .sleep_in(sleep), .wake_out(wake),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // Wait, bounded, for rx_valid (sel 1) or tx_ready (sel 0) at an edge
    task automatic wait_hi(input bit sel);
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while ((sel ? rx_valid : tx_ready) !== 1'b1 && n < 20000);
        if (n >= 20000)
            bad_count++;
    endtask : wait_hi
    // Offer a byte and note what the line should carry
    task automatic push(input logic [7:0] b);
        tx_data  <= b;
        tx_valid <= 1'b1;
        if (cfg.slip && (b == SLIP_END || b == SLIP_ESC))
        begin
            exp_tx.push_back(SLIP_ESC);
            exp_tx.push_back(b == SLIP_END ? SLIP_ESC_END : SLIP_ESC_ESC);
        end
        else
            exp_tx.push_back(b);
        wait_hi(1'b0);
    endtask : push
    task automatic wait_host();
        int n;
        n = 0;
        while (host.got_q.size() < exp_tx.size() && n < 30000)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 30000)
            bad_count++;
    endtask : wait_host
    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        check(16'({tx_line, tx_ready, rx_valid, wake}), 16'hc);
        check(ab_div, 16'(DIV));
        for (int i = 0; i < 13; i++)
        begin
            if (i == 11)
                check(16'(rts_n), 16'h0);
            exp_rx.push_back(rnd());
            host.send(exp_rx[i], DIV);
        end
        check(16'(rts_n), 16'h1);
        rx_ready <= 1'b1;
        foreach (exp_rx[i])
        begin
            wait_hi(1'b1);
            check(16'(rx_data), 16'(exp_rx[i]));
        end
        rx_ready <= 1'b0;
        cfg.slip <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        check(16'(rts_n), 16'h0);
        push(SLIP_END);
        push(SLIP_ESC);
        for (int i = 0; i < 4; i++)
            push(rnd());
        tx_valid <= 1'b0;
        wait_host();
        cts_n <= 1'b1;
        @(posedge ref_clk_in);
        push(8'h00);
        tx_valid <= 1'b0;
        repeat (3 * DIV) @(posedge ref_clk_in);
        check(16'(tx_line), 16'h1);
        cts_n <= 1'b0;
        repeat (DIV * 3 / 2) @(posedge ref_clk_in);
        check(16'(tx_line), 16'h0);
        wait_host();
        cfg.mode <= HUHP_H5;
        cts_n <= 1'b1;
        @(posedge ref_clk_in);
        push(8'h5a);
        tx_valid <= 1'b0;
        wait_host();
        cfg.sw_flow <= 1'b1;
        host.send(CH_XOFF, DIV);
        push(8'ha5);
        tx_valid <= 1'b0;
        repeat (2 * DIV) @(posedge ref_clk_in);
        check(16'({tx_line, rx_valid}), 16'h2);
        host.send(CH_XON, DIV);
        wait_host();
        check(16'(host.got_q.size()), 16'(exp_tx.size()));
        foreach (exp_tx[i])
            check(16'(host.got_q[i]), 16'(exp_tx[i]));
        arm <= 1'b1;
        @(posedge ref_clk_in);
        arm <= 1'b0;
        host.send(8'hff, 72);
        check(ab_div, 16'd72);
        check(16'(ab_pulses), 16'h1);
        bdiv  <= 16'd66;
        bload <= 1'b1;
        @(posedge ref_clk_in);
        bdiv  <= 16'd100;
        @(posedge ref_clk_in);
        bload <= 1'b0;
        host.send(8'h3c, 66);
        wait_hi(1'b1);
        check(16'(rx_data), 16'h3c);
        sleep <= 1'b1;
        @(posedge ref_clk_in);
        cts_n <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        check(16'(wake), 16'h1);
        sleep <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        check(16'(wake), 16'h0);
        print_verdict();
    end
    // Watchdog against a hang
    initial
    begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule : tb_top
